// >>> core/opsc_pkg.sv
// Shared constants for the op sampling capture block.
package opsc_pkg;
  localparam int OPSC_CNT_W = 27;
  localparam int OPSC_MAX_W = 23;
  localparam int OPSC_RND_W = 7;
  localparam int OPSC_PHYS_W = 52;
  // Register select codes on the model-specific register port.
  localparam logic [1:0] OPSC_SEL_FETCH_LIN = 2'h0;
  localparam logic [1:0] OPSC_SEL_FETCH_PHYS = 2'h1;
  localparam logic [1:0] OPSC_SEL_OP_CTL = 2'h2;
  localparam logic [1:0] OPSC_SEL_OP_ADDR = 2'h3;
  // Op control field positions.
  localparam int OPSC_CUR_LSB = 32;
  localparam int OPSC_CUR_MSB = 58;
  localparam int OPSC_MAXHI_LSB = 20;
  localparam int OPSC_MAXHI_MSB = 26;
  localparam int OPSC_SRC_BIT = 19;
  localparam int OPSC_VAL_BIT = 18;
  localparam int OPSC_EN_BIT = 17;
  localparam int OPSC_MAXLO_MSB = 15;
  // Counter bit ranges used on abort and for the compare.
  localparam int OPSC_CMP_LSB = 4;
  localparam int OPSC_ABORT_LSB = 7;
  // Reset values and the shift register feedback taps.
  localparam logic [26:0] OPSC_CNT_RST = 27'h0000000;
  localparam logic [6:0] OPSC_MAXHI_RST = 7'h00;
  localparam logic [15:0] OPSC_MAXLO_RST = 16'h0000;
  localparam logic [63:0] OPSC_ADDR_RST = 64'h0000000000000000;
  localparam logic [6:0] OPSC_LFSR_SEED = 7'h5A;
  localparam logic [6:0] OPSC_LFSR_TAPS = 7'h60;
  typedef enum logic [2:0] {
    OPSC_ST_COUNT = 3'b001,
    OPSC_ST_TAGGED = 3'b010,
    OPSC_ST_HELD = 3'b100
  } opsc_state_t;
endpackage

// >>> core/opsc_lfsr.sv
// Free-running Galois shift register giving a pseudo-random value.
`timescale 1ns/1ps
module opsc_lfsr #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] SEED = '1,
  parameter logic [WIDTH-1:0] TAPS = '1
) (
  input wire logic sys_clk,
  input wire logic reset,
  output logic [WIDTH-1:0] value
);
  typedef struct packed {
    logic [WIDTH-1:0] sr;
  } opsc_lfsr_t;
  opsc_lfsr_t cur_q;
  opsc_lfsr_t nxt_d;

  always_comb
  begin
    nxt_d = cur_q;
    nxt_d.sr = {1'b0, cur_q.sr[WIDTH-1:1]} ^ (cur_q.sr[0] ? TAPS : '0);
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cur_q <= SEED;
    else
      cur_q <= nxt_d;
  end

  assign value = cur_q.sr;

  a_lfsr_nonzero: assert property (@(posedge sys_clk) disable iff (reset) cur_q.sr != '0)
    else $error("Random source stuck at zero.");
endmodule // opsc_lfsr

// >>> core/opsc_core.sv
// Op sampling capture: interval counter, tagging, capture and register port.
`timescale 1ns/1ps
module opsc_core (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic msr_rd,
  input wire logic msr_wr,
  input wire logic [1:0] msr_sel,
  input wire logic [63:0] msr_wdata,
  output logic [63:0] msr_rdata,
  input wire logic op_dispatch,
  input wire logic op_tag_retire,
  input wire logic op_tag_abort,
  input wire logic [63:0] op_retire_addr,
  input wire logic op_retire_addr_bad,
  input wire logic fetch_done,
  input wire logic [63:0] fetch_lin_in,
  input wire logic [opsc_pkg::OPSC_PHYS_W-1:0] fetch_phys_in,
  input wire logic fetch_phys_ok,
  input wire logic fetch_valid_clear,
  output logic op_tag,
  output logic op_irq,
  output logic op_address_invalid,
  output logic fetch_sample_valid,
  output logic fetch_phys_addr_valid
);
  import opsc_pkg::*;

  typedef struct packed {
    opsc_state_t st;
    logic [OPSC_CNT_W-1:0] cnt;
    logic [6:0] max_hi;
    logic [15:0] max_lo;
    logic src;
    logic val;
    logic en;
    logic [63:0] op_addr;
    logic addr_bad;
    logic [63:0] flin;
    logic [OPSC_PHYS_W-1:0] fphys;
    logic fval;
    logic fpv;
    logic [63:0] rdata;
    logic irq;
    logic tag;
  } opsc_core_t;

  opsc_core_t cur_q;
  opsc_core_t nxt_d;
  logic [OPSC_RND_W-1:0] rnd;
  logic [OPSC_MAX_W-1:0] max_cnt;
  logic match;
  logic advance;
  logic ctl_wr;
  logic clear_val;

  opsc_lfsr #(
    .WIDTH(OPSC_RND_W),
    .SEED(OPSC_LFSR_SEED),
    .TAPS(OPSC_LFSR_TAPS)
  ) u_rnd (
    .sys_clk(sys_clk),
    .reset(reset),
    .value(rnd)
  );

  assign max_cnt = {cur_q.max_hi, cur_q.max_lo};
  assign match = cur_q.cnt[OPSC_CNT_W-1:OPSC_CMP_LSB] == max_cnt;
  assign advance = cur_q.src ? op_dispatch : 1'b1;
  assign ctl_wr = msr_wr && (msr_sel == OPSC_SEL_OP_CTL);
  assign clear_val = ctl_wr && !msr_wdata[OPSC_VAL_BIT];

  always_comb
  begin
    nxt_d = cur_q;
    nxt_d.irq = 1'b0;
    nxt_d.tag = 1'b0;
    if (ctl_wr)
    begin
      nxt_d.max_hi = msr_wdata[OPSC_MAXHI_MSB:OPSC_MAXHI_LSB];
      nxt_d.max_lo = msr_wdata[OPSC_MAXLO_MSB:0];
      nxt_d.src = msr_wdata[OPSC_SRC_BIT];
      nxt_d.en = msr_wdata[OPSC_EN_BIT];
      nxt_d.val = msr_wdata[OPSC_VAL_BIT];
    end
    if (msr_wr && msr_sel == OPSC_SEL_OP_ADDR)
      nxt_d.op_addr = msr_wdata;
    // load start count on valid clear
    if (clear_val)
    begin
      nxt_d.cnt = msr_wdata[OPSC_CUR_MSB:OPSC_CUR_LSB];
      nxt_d.st = OPSC_ST_COUNT;
    end
    else if (ctl_wr && msr_wdata[OPSC_VAL_BIT] && !cur_q.val)
      nxt_d.st = OPSC_ST_HELD;
    case (cur_q.st)
      OPSC_ST_COUNT:
      begin
        // count while enabled and not valid
        if (cur_q.en && !cur_q.val && !clear_val)
        begin
          if (match)
          begin
            nxt_d.tag = 1'b1;
            nxt_d.st = OPSC_ST_TAGGED;
          end
          else if (advance)
            nxt_d.cnt = cur_q.cnt + 27'h0000001;
        end
      end
      OPSC_ST_TAGGED:
      begin
        // capture on retire; set beats a same-cycle clear
        if (op_tag_retire)
        begin
          nxt_d.op_addr = op_retire_addr;
          nxt_d.addr_bad = op_retire_addr_bad;
          nxt_d.val = 1'b1;
          nxt_d.irq = 1'b1;
          nxt_d.st = OPSC_ST_HELD;
        end
        // abort reseeds the counter
        // A restart written in the same cycle outranks the abort reseed.
        else if (op_tag_abort && !clear_val)
        begin
          nxt_d.cnt = {20'h00000, rnd};
          nxt_d.st = OPSC_ST_COUNT;
        end
        else if (!nxt_d.en)
          nxt_d.st = OPSC_ST_COUNT;
      end
      OPSC_ST_HELD:
      begin
        if (!nxt_d.val)
          nxt_d.st = OPSC_ST_COUNT;
      end
      default:
        nxt_d.st = OPSC_ST_COUNT;
    endcase
    // fetch capture sets the flag; set wins over clear
    if (fetch_done)
    begin
      nxt_d.flin = fetch_lin_in;
      nxt_d.fphys = fetch_phys_in;
      nxt_d.fval = 1'b1;
      nxt_d.fpv = fetch_phys_ok;
    end
    else if (fetch_valid_clear)
    begin
      nxt_d.fval = 1'b0;
      nxt_d.fpv = 1'b0;
    end
    nxt_d.rdata = 64'h0000000000000000;
    if (msr_rd)
    begin
      case (msr_sel)
        OPSC_SEL_FETCH_LIN: nxt_d.rdata = cur_q.flin;
        OPSC_SEL_FETCH_PHYS: nxt_d.rdata = {12'h000, cur_q.fphys};
        OPSC_SEL_OP_CTL: nxt_d.rdata = {5'h00, cur_q.cnt, 5'h00, cur_q.max_hi, cur_q.src,
          cur_q.val, cur_q.en, 1'b0, cur_q.max_lo};
        OPSC_SEL_OP_ADDR: nxt_d.rdata = cur_q.op_addr;
        default: nxt_d.rdata = 64'h0000000000000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cur_q.st <= OPSC_ST_COUNT;
      cur_q.cnt <= OPSC_CNT_RST;
      cur_q.max_hi <= OPSC_MAXHI_RST;
      cur_q.max_lo <= OPSC_MAXLO_RST;
      cur_q.src <= 1'b0;
      cur_q.val <= 1'b0;
      cur_q.en <= 1'b0;
      cur_q.op_addr <= OPSC_ADDR_RST;
      cur_q.addr_bad <= 1'b0;
      cur_q.flin <= OPSC_ADDR_RST;
      cur_q.fphys <= OPSC_ADDR_RST[OPSC_PHYS_W-1:0];
      cur_q.fval <= 1'b0;
      cur_q.fpv <= 1'b0;
      cur_q.rdata <= OPSC_ADDR_RST;
      cur_q.irq <= 1'b0;
      cur_q.tag <= 1'b0;
    end
    else
      cur_q <= nxt_d;
  end

  assign msr_rdata = cur_q.rdata;
  assign op_irq = cur_q.irq;
  assign op_tag = cur_q.tag;
  assign op_address_invalid = cur_q.addr_bad;
  assign fetch_sample_valid = cur_q.fval;
  assign fetch_phys_addr_valid = cur_q.fpv;

  a_count_one_step: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.st == OPSC_ST_COUNT && cur_q.en && !cur_q.val && !match && !clear_val && advance)
    |=> cur_q.cnt == $past(cur_q.cnt) + 27'h0000001)
    else $error("Counter did not advance.");
  a_match_tags: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.st == OPSC_ST_COUNT && cur_q.en && !cur_q.val && match && !clear_val)
    |=> op_tag && cur_q.st == OPSC_ST_TAGGED)
    else $error("Match did not tag an op.");
  a_retire_sets_val: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.st == OPSC_ST_TAGGED && op_tag_retire)
    |=> cur_q.val && op_irq && cur_q.op_addr == $past(op_retire_addr))
    else $error("Retire did not capture.");
  a_held_stops: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.val && !ctl_wr) |=> $stable(cur_q.cnt))
    else $error("Counter moved while valid.");
  a_irq_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    op_irq |=> !op_irq)
    else $error("Interrupt longer than a cycle.");
  a_abort_reseed: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.st == OPSC_ST_TAGGED && !op_tag_retire && op_tag_abort && !clear_val)
    |=> cur_q.cnt[26:7] == 20'h00000 && !cur_q.val && cur_q.cnt[6:0] == $past(rnd))
    else $error("Abort did not reseed.");
  a_clear_loads: assert property (@(posedge sys_clk) disable iff (reset)
    (clear_val && !(cur_q.st == OPSC_ST_TAGGED && op_tag_retire))
    |=> cur_q.cnt == $past(msr_wdata[58:32]) && !cur_q.val)
    else $error("Clear did not load count.");
  a_phys_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (msr_rd && msr_sel == OPSC_SEL_FETCH_PHYS) |=> msr_rdata[63:52] == 12'h000)
    else $error("Reserved physical bits set.");
  a_fetch_lin_ro: assert property (@(posedge sys_clk) disable iff (reset)
    (!fetch_done) |=> $stable(cur_q.flin) && $stable(cur_q.fphys))
    else $error("Fetch address changed without fetch.");
  a_fetch_flags: assert property (@(posedge sys_clk) disable iff (reset)
    fetch_done |=> fetch_sample_valid && fetch_phys_addr_valid == $past(fetch_phys_ok))
    else $error("Fetch flags wrong.");
  a_phys_needs_val: assert property (@(posedge sys_clk) disable iff (reset)
    fetch_phys_addr_valid |-> fetch_sample_valid)
    else $error("Physical valid without fetch valid.");
  a_disabled_idle: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.st == OPSC_ST_COUNT && !cur_q.en && !ctl_wr) |=> $stable(cur_q.cnt) && !op_tag)
    else $error("Counter moved while disabled.");
  a_dispatch_gates: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.st == OPSC_ST_COUNT && cur_q.src && !op_dispatch && !ctl_wr) |=> $stable(cur_q.cnt))
    else $error("Counter moved without a dispatch.");
  a_addr_bad_capture: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.st == OPSC_ST_TAGGED && op_tag_retire)
    |=> op_address_invalid == $past(op_retire_addr_bad))
    else $error("Address invalid flag not captured.");
  a_fetch_capture: assert property (@(posedge sys_clk) disable iff (reset)
    fetch_done |=> cur_q.flin == $past(fetch_lin_in) && cur_q.fphys == $past(fetch_phys_in))
    else $error("Fetch addresses not captured.");
  a_ctl_reserved: assert property (@(posedge sys_clk) disable iff (reset)
    (msr_rd && msr_sel == OPSC_SEL_OP_CTL)
    |=> msr_rdata[63:59] == 5'h00 && msr_rdata[31:27] == 5'h00 && !msr_rdata[16])
    else $error("Reserved control bits set.");
  a_tag_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    op_tag |=> !op_tag)
    else $error("Tag longer than a cycle.");
  a_disable_drops: assert property (@(posedge sys_clk) disable iff (reset)
    (cur_q.st == OPSC_ST_TAGGED && !op_tag_retire && !op_tag_abort && ctl_wr
    && !msr_wdata[OPSC_EN_BIT]) |=> cur_q.st == OPSC_ST_COUNT)
    else $error("Disable did not drop the tag.");

  c_tag_retire: cover property (@(posedge sys_clk) disable iff (reset)
    op_tag ##[1:20] op_irq);
  c_tag_abort: cover property (@(posedge sys_clk) disable iff (reset)
    cur_q.st == OPSC_ST_TAGGED && op_tag_abort);
  c_clear_restart: cover property (@(posedge sys_clk) disable iff (reset)
    cur_q.val && clear_val);
  c_dispatch_tag: cover property (@(posedge sys_clk) disable iff (reset)
    cur_q.src && op_tag);
  c_fetch_set_wins: cover property (@(posedge sys_clk) disable iff (reset)
    fetch_done && fetch_valid_clear);
endmodule // opsc_core

// >>> bench/opsc_pipe.sv
// Behavioural model of the core pipeline that answers a tagged op.
`timescale 1ns/1ps
module opsc_pipe (
  input wire logic sys_clk,
  input wire logic op_tag,
  input wire logic abort_mode,
  input wire logic [3:0] lat,
  input wire logic [63:0] addr,
  input wire logic addr_bad,
  output logic op_tag_retire,
  output logic op_tag_abort,
  output logic [63:0] op_retire_addr,
  output logic op_retire_addr_bad
);
  initial
  begin
    op_tag_retire = 1'b0;
    op_tag_abort = 1'b0;
    op_retire_addr = 64'h0;
    op_retire_addr_bad = 1'b0;
    forever
    begin
      @(negedge sys_clk);
      if (op_tag === 1'b1)
      begin
        repeat (lat) @(posedge sys_clk);
        #1 op_tag_retire = !abort_mode;
        op_tag_abort = abort_mode;
        op_retire_addr = addr;
        op_retire_addr_bad = addr_bad;
        @(posedge sys_clk);
        #1 op_tag_retire = 1'b0;
        op_tag_abort = 1'b0;
        // Stale address is inverted so a late capture cannot match by luck.
        op_retire_addr = ~op_retire_addr;
        op_retire_addr_bad = ~op_retire_addr_bad;
      end
    end
  end
endmodule // opsc_pipe

// >>> bench/opsc_core_test.sv
// Self-checking bench for the op sampling capture block.
`timescale 1ns/1ps
module opsc_core_test;
  import opsc_pkg::*;
  logic sys_clk, reset, msr_rd, msr_wr, op_dispatch, fetch_done, fetch_phys_ok;
  logic fetch_valid_clear, op_tag_retire, op_tag_abort, op_retire_addr_bad, op_tag, op_irq;
  logic op_address_invalid, fetch_sample_valid, fetch_phys_addr_valid, ab, tb;
  logic [1:0] msr_sel;
  logic [63:0] msr_wdata, msr_rdata, fetch_lin_in, op_retire_addr, ta;
  logic [51:0] fetch_phys_in, pa;
  logic [6:0] mh;
  logic [15:0] ml;
  logic [3:0] lat;
  logic [31:0] sd = 32'h1CAD;
  logic pend = 1'b0;
  logic [127:0] q[$];
  int fails = 0, n_tests = 0, ntag = 0, nirq = 0, n, d;
  opsc_core dut (.sys_clk(sys_clk), .reset(reset), .msr_rd(msr_rd), .msr_wr(msr_wr),
    .msr_sel(msr_sel), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata), .op_dispatch(op_dispatch),
    .op_tag_retire(op_tag_retire), .op_tag_abort(op_tag_abort), .op_retire_addr(op_retire_addr),
    .op_retire_addr_bad(op_retire_addr_bad), .fetch_done(fetch_done),
    .fetch_lin_in(fetch_lin_in), .fetch_phys_in(fetch_phys_in), .fetch_phys_ok(fetch_phys_ok),
    .fetch_valid_clear(fetch_valid_clear), .op_tag(op_tag), .op_irq(op_irq),
    .op_address_invalid(op_address_invalid), .fetch_sample_valid(fetch_sample_valid),
    .fetch_phys_addr_valid(fetch_phys_addr_valid));
  opsc_pipe pipe (.sys_clk(sys_clk), .op_tag(op_tag), .abort_mode(ab), .lat(lat), .addr(ta),
    .addr_bad(tb), .op_tag_retire(op_tag_retire), .op_tag_abort(op_tag_abort),
    .op_retire_addr(op_retire_addr), .op_retire_addr_bad(op_retire_addr_bad));
  function automatic logic [31:0] rnd();
    sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
    return sd;
  endfunction
  // Flags are packed as source select, valid, enable.
  function automatic logic [63:0] ctl(logic [26:0] c, logic [6:0] h, logic [2:0] f,
    logic [15:0] l);
    return {5'h00, c, 5'h00, h, f, 1'b0, l};
  endfunction
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(logic [1:0] s, logic [63:0] v);
    @(posedge sys_clk);
    #1 msr_wr = 1'b1;
    msr_sel = s;
    msr_wdata = v;
    @(posedge sys_clk);
    #1 msr_wr = 1'b0;
    msr_wdata = ~v;
  endtask
  task automatic rd(logic [1:0] s, logic [63:0] e, logic [63:0] m);
    @(posedge sys_clk);
    #1 msr_rd = 1'b1;
    msr_sel = s;
    q.push_back({e & m, m});
    @(posedge sys_clk);
    #1 msr_rd = 1'b0;
  endtask
  task automatic wt(logic i);
    n = 0;
    while ((i ? op_irq : op_tag) !== 1'b1 && n < 300)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) pend <= msr_rd;
  // Read data is looked at mid-cycle, once the answering edge has settled.
  always @(negedge sys_clk)
  begin
    if (op_tag === 1'b1) ntag++;
    if (op_irq === 1'b1) nirq++;
    if (pend)
    begin
      chk("msr_rdata", msr_rdata & q[0][63:0], q[0][127:64]);
      void'(q.pop_front());
    end
  end
  initial
  begin
    #300000;
    fails++;
    results();
  end
  initial
  begin
    {reset, msr_rd, msr_wr, op_dispatch, fetch_done, fetch_phys_ok, fetch_valid_clear} = 7'h40;
    {ab, tb, lat, msr_sel, msr_wdata, fetch_lin_in, fetch_phys_in, ta} = '0;
    repeat (10) @(posedge sys_clk);
    #1 reset = 1'b0;
    rd(OPSC_SEL_OP_CTL, 64'h0, '1);
    rd(OPSC_SEL_OP_ADDR, OPSC_ADDR_RST, '1);
    ta = {rnd(), rnd()};
    wr(OPSC_SEL_OP_ADDR, ta);
    rd(OPSC_SEL_OP_ADDR, ta, '1);
    wr(OPSC_SEL_OP_CTL, 64'hF8000000F8010000 | ctl(27'h33, 7'h00, 3'b000, 16'h0005));
    rd(OPSC_SEL_OP_CTL, ctl(27'h33, 7'h00, 3'b000, 16'h0005), '1);
    n = ntag;
    repeat (40) @(negedge sys_clk);
    chk("tag while disabled", 64'(ntag), 64'(n));
    $display("Test reset and reserved bits done");
    for (int i = 0; i < 2; i++)
    begin
      mh = i ? 7'h01 : 7'h00;
      ml = i ? 16'h0000 : 16'h0002;
      ta = {rnd(), rnd()};
      tb = sd[3];
      lat = i ? 4'h5 : 4'h1;
      wr(OPSC_SEL_OP_CTL, ctl({mh, ml, 4'h0} - 27'h10, mh, 3'b001, ml));
      wt(1'b0);
      chk("tag delay", 64'(n >= 17 && n <= 19), 64'h1);
      wt(1'b1);
      chk("irq seen", 64'(n < 300), 64'h1);
      chk("addr invalid", 64'(op_address_invalid), 64'(tb));
      rd(OPSC_SEL_OP_CTL, ctl({mh, ml, 4'h0}, mh, 3'b011, ml), '1);
      rd(OPSC_SEL_OP_ADDR, ta, '1);
    end
    $display("Test retire capture done");
    ab = 1'b1;
    d = nirq;
    wr(OPSC_SEL_OP_CTL, ctl(27'h10, 7'h00, 3'b001, 16'h0002));
    wt(1'b0);
    chk("abort tag seen", 64'(n < 300), 64'h1);
    repeat (10) @(negedge sys_clk);
    rd(OPSC_SEL_OP_CTL, 64'h0000000000020000, 64'h07FFFF0000060000);
    chk("irq after abort", 64'(nirq), 64'(d));
    // A reseeded counter may tag again; disable and let late aborts drain before retiring.
    wr(OPSC_SEL_OP_CTL, ctl(27'h0, 7'h00, 3'b000, 16'h0002));
    repeat (10) @(negedge sys_clk);
    $display("Test abort done");
    ab = 1'b0;
    wr(OPSC_SEL_OP_CTL, ctl(27'h10, 7'h00, 3'b101, 16'h0002));
    n = ntag;
    repeat (30) @(negedge sys_clk);
    chk("tag without dispatch", 64'(ntag), 64'(n));
    d = 0;
    for (n = 0; n < 300 && op_tag !== 1'b1; n++)
    begin
      @(posedge sys_clk);
      #1 op_dispatch = sd[0];
      d += int'(sd[0]);
      void'(rnd());
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    #1 op_dispatch = 1'b0;
    chk("dispatch count", 64'(d >= 16 && d <= 18), 64'h1);
    wt(1'b1);
    chk("irq after dispatch", 64'(n < 300), 64'h1);
    $display("Test dispatch counting done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      #1 fetch_done = 1'b1;
      // The second capture meets a clear in the same cycle, and the capture must win.
      fetch_valid_clear = k == 1;
      ta = {rnd(), rnd()};
      pa = 52'({rnd(), rnd()});
      fetch_lin_in = ta;
      fetch_phys_in = pa;
      fetch_phys_ok = k == 0;
      @(posedge sys_clk);
      #1 fetch_done = 1'b0;
      fetch_valid_clear = 1'b0;
      fetch_lin_in = ~ta;
      fetch_phys_in = ~pa;
      @(negedge sys_clk);
      chk("fetch valid", 64'(fetch_sample_valid), 64'h1);
      chk("phys valid", 64'(fetch_phys_addr_valid), 64'(k == 0));
      wr(OPSC_SEL_FETCH_LIN, ~ta);
      wr(OPSC_SEL_FETCH_PHYS, ~ta);
      rd(OPSC_SEL_FETCH_LIN, ta, '1);
      rd(OPSC_SEL_FETCH_PHYS, {12'h000, pa}, k ? 64'hFFF0000000000000 : '1);
      @(posedge sys_clk);
      #1 fetch_valid_clear = 1'b1;
      @(posedge sys_clk);
      #1 fetch_valid_clear = 1'b0;
      @(negedge sys_clk);
      chk("fetch cleared", 64'({fetch_sample_valid, fetch_phys_addr_valid}), 64'h0);
    end
    $display("Test fetch capture done");
    repeat (4) @(posedge sys_clk);
    results();
  end
endmodule // opsc_core_test
